/* rtl/irr_pkg.sv */
// constants for the ide interrupt routing and read-ahead block
package irr_pkg;
    // configuration register indices
    localparam logic [7:0] IDX_PROG_IF = 8'h09;
    localparam logic [7:0] IDX_CHIP_CFG = 8'h50;
    localparam logic [7:0] IDX_SEC_SETUP = 8'h57;
    localparam logic [7:0] IDX_BURST_LEN = 8'h59;
    // field positions
    localparam int PROG_IF_PRI_NATIVE_BIT = 0;
    localparam int PROG_IF_SEC_NATIVE_BIT = 2;
    localparam int CHIP_CFG_PRI_IRQ_BIT = 2;
    localparam int SEC_SETUP_IRQ_BIT = 4;
    localparam int SEC_SETUP_RSVD_BIT = 5;
    // reset values
    localparam logic [7:0] PROG_IF_RESET = 8'h00;
    localparam logic [7:0] CHIP_CFG_RESET = 8'h00;
    localparam logic [7:0] SEC_SETUP_RESET = 8'h0C;
    localparam logic [7:0] BURST_LEN_RESET = 8'h40;
    // bytes per read-ahead unit is 2**QW_SHIFT
    localparam int QW_SHIFT = 3;
    localparam int RA_BYTES_W = 11;
    // legacy task-file ports
    localparam logic [9:0] PRI_CMD_BASE = 10'h1F0;
    localparam logic [9:0] SEC_CMD_BASE = 10'h170;
    localparam logic [9:0] PRI_CTL_PORT = 10'h3F6;
    localparam logic [9:0] SEC_CTL_PORT = 10'h376;
    localparam logic [9:0] PRI_ALT_PORT = 10'h3F7;
    localparam logic [9:0] SEC_ALT_PORT = 10'h377;
    localparam logic [2:0] CMD_REG_OFS = 3'h7;
    // drive read commands that start read-ahead
    localparam logic [7:0] ATA_READ = 8'h20;
    localparam logic [7:0] ATA_READ_NR = 8'h21;
    localparam logic [7:0] ATA_READ_MULT = 8'hC4;
    // channel indices
    localparam int CH_PRI = 0;
    localparam int CH_SEC = 1;
    localparam int NUM_CH = 2;
endpackage

/* rtl/irr_irq_latch.sv */
// sticky pending flag for one channel's drive interrupt
`timescale 1ns/10ps
module irr_irq_latch (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event and clear
    input wire logic irq_in,
    input wire logic clr,
    // state
    output logic pending_q
);
    logic pending_d;

    // set wins over a clear in the same cycle
    always_comb begin
        pending_d = pending_q;
        if (clr) begin
            pending_d = 1'b0;
        end
        if (irq_in) begin
            pending_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
        end
    end
endmodule

/* rtl/irr_top.sv */
// interrupt routing, read-ahead trigger and chip selects of the ide bridge
//
// Functional notes
// R01: strap low at reset forces both channels into legacy mode.
// R02: strap high lets programming interface bits pick native per channel.
// R03: legacy channel decodes task file at standard isa ports.
// R04: legacy primary interrupt goes to irq14, secondary to irq15.
// R05: native channel leaves standard ports and signals interrupt on inta.
// R06: both native channels share the single inta line.
// R07: primary pending shows in chip configuration bit 2; host reads first.
// R08: secondary pending shows in setup status bit 4; host reads next.
// R09: host treats inta with no status set as another agent.
// R10: read command written to command port loads read-ahead count.
// R11: inta is open collector, pulled low only while pending.
// R12: irq14 output is tri-state, released when not in use.
// R13: host bus mode strap high selects pci host interface mode.
// R14: alternate port 3f7 decode follows the decode enable input.
// R15: primary command select for 1fx, control select for 3f6.
// R16: secondary command select for 17x, control select for 376.
// R17: secondary channel has its own read and write strobes.
// R18: reading secondary setup status clears its interrupt pending bit.
// R19: burst length counts quad words, eight bytes each.
// R20: drive interrupt sets sticky pending until software clears it.
`timescale 1ns/10ps
module irr_top
    import irr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // straps
    input wire logic legacy_mode_strap,
    input wire logic host_bus_mode_strap,
    input wire logic chip_enable_strap,
    input wire logic alt_port_decode_enable_n,
    // configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // host i/o access
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [9:0] io_addr,
    input wire logic [7:0] io_wdata,
    // read-ahead consumption, one quad word per pulse
    input wire logic ra_take,
    output logic [7:0] ra_qw_left,
    output logic [RA_BYTES_W-1:0] ra_bytes_left,
    // drive side
    input wire logic primary_drive_irq_in,
    input wire logic secondary_drive_irq_in,
    output logic primary_cmd_select_n,
    output logic primary_ctl_select_n,
    output logic secondary_cmd_select_n,
    output logic secondary_ctl_select_n,
    output logic drive_read_strobe_n,
    output logic drive_write_strobe_n,
    output logic sec_drive_read_strobe_n,
    output logic sec_drive_write_strobe_n,
    output logic drive_reset_out_n,
    // system interrupts
    output logic irq14_o,
    output logic irq14_oe,
    output logic irq15_o,
    output logic inta_n_o,
    output logic inta_n_oe,
    // mode status
    output logic pci_mode,
    output logic [NUM_CH-1:0] chan_native
);
    // strap capture and mode
    logic strap_q, strap_d, pci_mode_d, drive_reset_out_n_d;
    logic [NUM_CH-1:0] native_d;
    logic [7:0] prog_if_q, prog_if_d;

    // strap is caught by a clocked process while reset is held
    always_comb begin
        strap_d = rst ? legacy_mode_strap : strap_q;
        pci_mode_d = host_bus_mode_strap; // R13
        drive_reset_out_n_d = 1'b1;
        native_d = '0; // R01
        if (strap_q) begin
            native_d[CH_PRI] = prog_if_q[PROG_IF_PRI_NATIVE_BIT]; // R02
            native_d[CH_SEC] = prog_if_q[PROG_IF_SEC_NATIVE_BIT]; // R02
        end
    end

    always_ff @(posedge clk) begin
        strap_q <= strap_d;
        if (rst) begin
            pci_mode <= 1'b0;
            chan_native <= '0;
            drive_reset_out_n <= 1'b0;
        end else begin
            pci_mode <= pci_mode_d;
            chan_native <= native_d;
            drive_reset_out_n <= drive_reset_out_n_d;
        end
    end

    // configuration registers
    logic [7:0] chip_cfg_q, chip_cfg_d;
    logic [7:0] sec_setup_q, sec_setup_d;
    logic [7:0] burst_q, burst_d;
    logic [7:0] rdata_d;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] irq_raw;
    logic [NUM_CH-1:0] irq_clr;

    always_comb begin
        prog_if_d = prog_if_q;
        chip_cfg_d = chip_cfg_q;
        sec_setup_d = sec_setup_q;
        burst_d = burst_q;
        irq_clr = '0;
        rdata_d = 8'h00;
        if (cfg_wr) begin
            unique case (cfg_index)
                IDX_PROG_IF: prog_if_d = cfg_wdata;
                IDX_CHIP_CFG: begin
                    chip_cfg_d = cfg_wdata;
                    irq_clr[CH_PRI] = cfg_wdata[CHIP_CFG_PRI_IRQ_BIT];
                end
                IDX_SEC_SETUP: sec_setup_d = cfg_wdata;
                IDX_BURST_LEN: burst_d = cfg_wdata;
                default: ;
            endcase
        end
        if (cfg_rd) begin
            unique case (cfg_index)
                IDX_PROG_IF: rdata_d = prog_if_q;
                IDX_CHIP_CFG: begin
                    rdata_d = chip_cfg_q;
                    rdata_d[CHIP_CFG_PRI_IRQ_BIT] = pend[CH_PRI]; // R07
                end
                IDX_SEC_SETUP: begin
                    rdata_d = sec_setup_q;
                    rdata_d[SEC_SETUP_IRQ_BIT] = pend[CH_SEC]; // R08
                    rdata_d[SEC_SETUP_RSVD_BIT] = 1'b0;
                    irq_clr[CH_SEC] = 1'b1; // R18
                end
                IDX_BURST_LEN: rdata_d = burst_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prog_if_q <= PROG_IF_RESET;
            chip_cfg_q <= CHIP_CFG_RESET;
            sec_setup_q <= SEC_SETUP_RESET;
            burst_q <= BURST_LEN_RESET;
            cfg_rdata <= 8'h00;
        end else begin
            prog_if_q <= prog_if_d;
            chip_cfg_q <= chip_cfg_d;
            sec_setup_q <= sec_setup_d;
            burst_q <= burst_d;
            cfg_rdata <= rdata_d;
        end
    end

    // pending flags, one per channel
    assign irq_raw = {secondary_drive_irq_in, primary_drive_irq_in};

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
            irr_irq_latch u_latch (
                .clk(clk),
                .rst(rst),
                .irq_in(irq_raw[ch]), // R20
                .clr(irq_clr[ch]),
                .pending_q(pend[ch])
            );
        end
    endgenerate

    // interrupt routing
    logic irq14_d, irq14_oe_d, irq15_d, inta_oe_d;

    always_comb begin
        irq14_oe_d = !native_d[CH_PRI]; // R12
        irq14_d = !native_d[CH_PRI] && pend[CH_PRI]; // R04
        irq15_d = !native_d[CH_SEC] && pend[CH_SEC]; // R04
        // both native channels fold onto one shared line
        inta_oe_d = |(native_d & pend); // R05 R06 R11
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq14_o <= 1'b0;
            irq14_oe <= 1'b0;
            irq15_o <= 1'b0;
            inta_n_o <= 1'b0;
            inta_n_oe <= 1'b0;
        end else begin
            irq14_o <= irq14_d;
            irq14_oe <= irq14_oe_d;
            irq15_o <= irq15_d;
            inta_n_o <= 1'b0; // R11
            inta_n_oe <= inta_oe_d;
        end
    end

    // legacy port decode and strobes
    logic io_act;
    logic [NUM_CH-1:0] hit_cmd, hit_ctl;
    logic pcs_d, pctl_d, scs_d, sctl_d;
    logic prd_d, pwr_d, srd_d, swr_d;

    always_comb begin
        io_act = (io_rd || io_wr) && chip_enable_strap;
        // native channels leave the standard ports to other agents
        hit_cmd[CH_PRI] = !native_d[CH_PRI] && io_addr[9:3] == PRI_CMD_BASE[9:3]; // R03 R15
        hit_cmd[CH_SEC] = !native_d[CH_SEC] && io_addr[9:3] == SEC_CMD_BASE[9:3]; // R03 R16
        hit_ctl[CH_PRI] = !native_d[CH_PRI] && (io_addr == PRI_CTL_PORT
            || (!alt_port_decode_enable_n && io_addr == PRI_ALT_PORT)); // R14 R15
        hit_ctl[CH_SEC] = !native_d[CH_SEC] && (io_addr == SEC_CTL_PORT
            || (!alt_port_decode_enable_n && io_addr == SEC_ALT_PORT)); // R14 R16
        pcs_d = !(io_act && hit_cmd[CH_PRI]);
        pctl_d = !(io_act && hit_ctl[CH_PRI]);
        scs_d = !(io_act && hit_cmd[CH_SEC]);
        sctl_d = !(io_act && hit_ctl[CH_SEC]);
        prd_d = !(io_act && io_rd && (hit_cmd[CH_PRI] || hit_ctl[CH_PRI]));
        pwr_d = !(io_act && io_wr && (hit_cmd[CH_PRI] || hit_ctl[CH_PRI]));
        srd_d = !(io_act && io_rd && (hit_cmd[CH_SEC] || hit_ctl[CH_SEC])); // R17
        swr_d = !(io_act && io_wr && (hit_cmd[CH_SEC] || hit_ctl[CH_SEC])); // R17
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            primary_cmd_select_n <= 1'b1;
            primary_ctl_select_n <= 1'b1;
            secondary_cmd_select_n <= 1'b1;
            secondary_ctl_select_n <= 1'b1;
            drive_read_strobe_n <= 1'b1;
            drive_write_strobe_n <= 1'b1;
            sec_drive_read_strobe_n <= 1'b1;
            sec_drive_write_strobe_n <= 1'b1;
        end else begin
            primary_cmd_select_n <= pcs_d;
            primary_ctl_select_n <= pctl_d;
            secondary_cmd_select_n <= scs_d;
            secondary_ctl_select_n <= sctl_d;
            drive_read_strobe_n <= prd_d;
            drive_write_strobe_n <= pwr_d;
            sec_drive_read_strobe_n <= srd_d;
            sec_drive_write_strobe_n <= swr_d;
        end
    end

    // read-ahead counter
    logic ra_load;
    logic [7:0] ra_qw_d;
    logic [RA_BYTES_W-1:0] ra_bytes_d;

    always_comb begin
        ra_load = io_act && io_wr && io_addr[2:0] == CMD_REG_OFS
            && (hit_cmd[CH_PRI] || hit_cmd[CH_SEC])
            && (io_wdata == ATA_READ || io_wdata == ATA_READ_NR || io_wdata == ATA_READ_MULT); // R10
        ra_qw_d = ra_qw_left;
        if (ra_load) begin
            ra_qw_d = burst_q; // R10
        end else if (ra_take && ra_qw_left != 8'h00) begin
            ra_qw_d = ra_qw_left - 8'h01;
        end
        // zero burst length reads as no read-ahead, no wrap to 256
        ra_bytes_d = RA_BYTES_W'({ra_qw_d, 3'b000}) ; // R19
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ra_qw_left <= 8'h00;
            ra_bytes_left <= '0;
        end else begin
            ra_qw_left <= ra_qw_d;
            ra_bytes_left <= ra_bytes_d;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_cmd_read_write;
        io_wr && chip_enable_strap && !native_d[CH_PRI] && io_addr == 10'h1F7
            && io_wdata == ATA_READ;
    endsequence

    chk_strap_legacy: assert property (!strap_q |=> chan_native == '0) // R01
        else $error("native mode with strap low");
    chk_irq14_route: assert property (!native_d[CH_PRI] && pend[CH_PRI] |=> irq14_o && irq14_oe) // R04
        else $error("primary legacy interrupt not on irq14");
    chk_irq15_route: assert property (!native_d[CH_SEC] && pend[CH_SEC] // R04
        |=> irq15_o && inta_n_oe == $past(native_d[CH_PRI] && pend[CH_PRI]))
        else $error("secondary legacy interrupt not on irq15");
    chk_inta_shared: assert property (native_d == 2'b11 && $rose(pend[CH_SEC]) |=> inta_n_oe && !inta_n_o) // R06
        else $error("shared inta not pulled low");
    chk_inta_release: assert property ((native_d & pend) == '0 |=> !inta_n_oe) // R11
        else $error("inta driven with nothing pending");
    chk_sec_read_clear: assert property (cfg_rd && cfg_index == IDX_SEC_SETUP && !secondary_drive_irq_in // R18
        |=> !pend[CH_SEC] && cfg_rdata[SEC_SETUP_IRQ_BIT] == $past(pend[CH_SEC])
        && cfg_rdata[SEC_SETUP_RSVD_BIT] == 1'b0)
        else $error("secondary pending not cleared by read");
    chk_pending_hold: assert property (pend[CH_PRI] && !irq_clr[CH_PRI] |=> pend[CH_PRI]) // R20
        else $error("primary pending lost without clear");
    chk_ra_load: assert property (s_cmd_read_write |=> ra_qw_left == $past(burst_q)
        && ra_bytes_left == RA_BYTES_W'({$past(burst_q), 3'b000})) // R10 R19
        else $error("read-ahead count not loaded from burst length");
    chk_pri_cmd_cs: assert property (io_rd && chip_enable_strap && !native_d[CH_PRI] && io_addr == 10'h1F3
        |=> !primary_cmd_select_n && !drive_read_strobe_n && sec_drive_read_strobe_n) // R15 R17
        else $error("primary command select missing");
    chk_alt_port: assert property (io_rd && chip_enable_strap && io_addr == PRI_ALT_PORT && alt_port_decode_enable_n
        |=> primary_ctl_select_n) // R14
        else $error("alternate port decoded while disabled");
endmodule

/* tb/irr_host_model.sv */
// host side model: resolves irq14 and shared inta wires, other inta agent
`timescale 1ns/10ps
module irr_host_model (
    // clock
    input wire logic clk,
    // device interrupt pins
    input wire logic irq14_o,
    input wire logic irq14_oe,
    input wire logic inta_n_o,
    input wire logic inta_n_oe,
    // another agent sharing inta
    input wire logic other_req,
    // resolved wires
    output logic irq14_wire,
    output logic inta_n_wire
);
    logic float_q = 1'b0;
    // a released line must not look like a held value, so it toggles
    always @(posedge clk) float_q <= ~float_q;
    assign irq14_wire = irq14_oe ? irq14_o : float_q;
    // pull-up on the shared line, low while any agent pulls
    assign inta_n_wire = ~((inta_n_oe && !inta_n_o) || other_req);
endmodule

/* tb/tb_top.sv */
// self-checking bench for the interrupt routing and read-ahead block
`timescale 1ns/10ps
module tb_top;
    import irr_pkg::*;
    localparam logic [9:0] A_T [8] = '{10'h1F7, 10'h1F0, 10'h3F6, 10'h177, 10'h376, 10'h3F7, 10'h2F0, 10'h3F7};
    localparam logic [7:0] P_T [8] = '{8'h7B, 8'h77, 8'hBB, 8'hDD, 8'hEE, 8'hFF, 8'hFF, 8'hB7};
    localparam logic [7:0] W_T = 8'h15;
    localparam logic [7:0] I_T [5] = '{8'h09, 8'h50, 8'h57, 8'h59, 8'h33};
    localparam logic [7:0] R_T [5] = '{8'h00, 8'h00, 8'h0C, 8'h40, 8'h00};
    logic clk = 1'b0, rst = 1'b1, lgc_strap = 1'b0, host_strap = 1'b1, en_strap = 1'b1, alt_n = 1'b1;
    logic cfg_wr = 1'b0, cfg_rd = 1'b0, io_wr = 1'b0, io_rd = 1'b0, ra_take = 1'b0;
    logic pri_irq = 1'b0, sec_irq = 1'b0, other_req = 1'b0;
    logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, io_wdata = 8'h00, cfg_rdata, ra_qw_left, pins, rd;
    logic [9:0] io_addr = 10'h000;
    logic [RA_BYTES_W-1:0] ra_bytes_left;
    logic pcs_n, pls_n, scs_n, sls_n, rs_n, ws_n, srs_n, sws_n, drive_reset_out_n_n;
    logic irq14_o, irq14_oe, irq15_o, inta_n_o, inta_n_oe, pci_mode, irq14_wire, inta_n_wire;
    logic [NUM_CH-1:0] chan_native;
    logic [1:0] src;
    int error_cnt = 0;
    int samples_checked = 0;
    always #2 clk = ~clk;
    irr_top i_irr_top (.clk(clk), .rst(rst), .legacy_mode_strap(lgc_strap), .host_bus_mode_strap(host_strap),
        .chip_enable_strap(en_strap), .alt_port_decode_enable_n(alt_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .ra_take(ra_take), .ra_qw_left(ra_qw_left),
        .ra_bytes_left(ra_bytes_left), .primary_drive_irq_in(pri_irq), .secondary_drive_irq_in(sec_irq),
        .primary_cmd_select_n(pcs_n), .primary_ctl_select_n(pls_n), .secondary_cmd_select_n(scs_n),
        .secondary_ctl_select_n(sls_n), .drive_read_strobe_n(rs_n), .drive_write_strobe_n(ws_n),
        .sec_drive_read_strobe_n(srs_n), .sec_drive_write_strobe_n(sws_n), .drive_reset_out_n(drive_reset_out_n_n),
        .irq14_o(irq14_o), .irq14_oe(irq14_oe), .irq15_o(irq15_o), .inta_n_o(inta_n_o),
        .inta_n_oe(inta_n_oe), .pci_mode(pci_mode), .chan_native(chan_native));
    irr_host_model i_irr_host_model (.clk(clk), .irq14_o(irq14_o), .irq14_oe(irq14_oe), .inta_n_o(inta_n_o),
        .inta_n_oe(inta_n_oe), .other_req(other_req), .irq14_wire(irq14_wire), .inta_n_wire(inta_n_wire));
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_cnt(input string what, input logic [RA_BYTES_W-1:0] exp, input logic [RA_BYTES_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic do_reset(input logic strap, input logic host);
        @(posedge clk);
        rst <= 1'b1;
        lgc_strap <= strap;
        host_strap <= host;
        repeat (4) @(posedge clk);
        #1 cmp8("drive reset held", 8'h00, {7'h00, drive_reset_out_n_n});
        @(posedge clk);
        rst <= 1'b0;
        settle();
        cmp8("drive reset released", 8'h01, {7'h00, drive_reset_out_n_n});
    endtask
    // data shows the cycle after the taking edge and stands one cycle
    task automatic cfg(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        cfg_wr <= wr;
        cfg_rd <= !wr;
        cfg_index <= idx;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        #1 rd = cfg_rdata;
    endtask
    task automatic io_acc(input logic wr, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        io_wr <= wr;
        io_rd <= !wr;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1 pins = {pcs_n, pls_n, scs_n, sls_n, rs_n, ws_n, srs_n, sws_n};
    endtask
    task automatic take(input int n);
        repeat (n) begin
            @(posedge clk);
            ra_take <= 1'b1;
            @(posedge clk);
            ra_take <= 1'b0;
        end
        #1;
    endtask
    task automatic irq_pulse(input logic p, input logic s);
        @(posedge clk);
        pri_irq <= p;
        sec_irq <= s;
        @(posedge clk);
        pri_irq <= 1'b0;
        sec_irq <= 1'b0;
        settle();
    endtask
    // polling order of a shared inta service: primary first, then secondary
    task automatic service(output logic [1:0] s);
        cfg(1'b0, IDX_CHIP_CFG, 8'h00);
        s[0] = rd[2];
        cfg(1'b0, IDX_SEC_SETUP, 8'h00);
        s[1] = rd[4];
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        do_reset(1'b0, 1'b1);
        cmp8("pci_mode", 8'h01, {7'h00, pci_mode});
        for (int i = 0; i < 5; i++) begin
            cfg(1'b0, I_T[i], 8'h00);
            cmp8("reset value", R_T[i], rd);
        end
        cfg(1'b1, IDX_PROG_IF, 8'h05);
        settle();
        cmp8("native legacy strap", 8'h00, {6'h00, chan_native});
        for (int i = 0; i < 8; i++) begin
            if (i == 7) begin
                @(posedge clk);
                alt_n <= 1'b0;
            end
            io_acc(W_T[i], A_T[i], 8'h00);
            cmp8("select pins", P_T[i], pins);
        end
        io_acc(1'b0, 10'h1F3, 8'h00);
        cmp8("select pins", 8'h77, pins);
        io_acc(1'b1, 10'h1F7, ATA_READ);
        cmp8("ra_qw", 8'h40, ra_qw_left);
        cmp_cnt("ra_bytes", 11'h200, ra_bytes_left);
        cfg(1'b1, IDX_BURST_LEN, 8'h03);
        io_acc(1'b1, 10'h177, ATA_READ_MULT);
        take(1);
        cmp_cnt("ra_bytes", 11'h010, ra_bytes_left);
        io_acc(1'b1, 10'h1F7, 8'h30);
        io_acc(1'b1, 10'h1F6, ATA_READ);
        cmp8("ra_qw", 8'h02, ra_qw_left);
        io_acc(1'b1, 10'h1F7, ATA_READ_NR);
        take(4);
        cmp8("ra_qw floor", 8'h00, ra_qw_left);
        irq_pulse(1'b1, 1'b0);
        cmp8("legacy pri irq", 8'h0C, {4'h0, irq14_wire, irq14_oe, irq15_o, inta_n_oe});
        cfg(1'b0, IDX_CHIP_CFG, 8'h00);
        cmp8("chip_cfg pending", 8'h04, rd & 8'h04);
        cfg(1'b1, IDX_CHIP_CFG, 8'h04);
        irq_pulse(1'b0, 1'b1);
        cmp8("legacy sec irq", 8'h06, {4'h0, irq14_wire, irq14_oe, irq15_o, inta_n_oe});
        cfg(1'b0, IDX_SEC_SETUP, 8'h00);
        cmp8("sec_setup pending", 8'h1C, rd);
        cfg(1'b0, IDX_SEC_SETUP, 8'h00);
        cmp8("sec_setup cleared", 8'h0C, rd);
        settle();
        cmp8("irq15 released", 8'h00, {7'h00, irq15_o});
        @(posedge clk);
        en_strap <= 1'b0;
        io_acc(1'b1, 10'h1F7, 8'h00);
        cmp8("chip disabled", 8'hFF, pins);
        @(posedge clk);
        en_strap <= 1'b1;
        do_reset(1'b1, 1'b0);
        cmp8("pci_mode", 8'h00, {7'h00, pci_mode});
        cfg(1'b1, IDX_PROG_IF, 8'h01);
        settle();
        cmp8("native mixed", 8'h01, {6'h00, chan_native});
        cfg(1'b1, IDX_PROG_IF, 8'h05);
        io_acc(1'b1, 10'h1F7, 8'h00);
        cmp8("native pri ports", 8'hFF, pins);
        io_acc(1'b0, 10'h177, 8'h00);
        cmp8("native sec ports", 8'hFF, pins);
        irq_pulse(1'b1, 1'b1);
        cmp8("inta both", 8'h04, {4'h0, inta_n_wire, inta_n_oe, irq15_o, irq14_oe});
        service(src);
        cmp8("poll both", 8'h03, {6'h00, src});
        cfg(1'b1, IDX_CHIP_CFG, 8'h04);
        settle();
        cmp8("inta released", 8'h08, {4'h0, inta_n_wire, inta_n_oe, irq15_o, irq14_oe});
        @(posedge clk);
        other_req <= 1'b1;
        service(src);
        cmp8("poll other agent", 8'h00, {5'h00, src, inta_n_wire});
        other_req <= 1'b0;
        give_verdict();
    end
endmodule
